/* File: cirq_bus_model.sv */
// Purpose: Bus-side model of the other CAN nodes
// Assumes: One bit sample every BIT_CYC clocks
// Notes: A released bus reads recessive and idle
`default_nettype none
module cirq_bus_model #(
	parameter int BIT_CYC = 2
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Bench command
	input wire logic dominant_i,
	// Bus view
	output logic bit_tick_o,
	output logic recessive_o,
	output logic activity_o,
	output logic idle_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt_q, cnt_d;
	always_comb begin
		cnt_d = (cnt_q == 8'(BIT_CYC - 1)) ? 8'h00 : cnt_q + 8'h01;
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) cnt_q <= 8'h00;
		else cnt_q <= cnt_d;
	end
	assign bit_tick_o = cnt_q == 8'h00;
	assign recessive_o = !dominant_i;
	assign activity_o = dominant_i;
	assign idle_o = !dominant_i;
endmodule
`default_nettype wire

/* File: cirq_checker.sv */
// Purpose: Port assertions for the CAN interrupt control block
// Assumes: One clock domain, reset active high
// Notes: Bound to every cirq_ctrl instance from the bench
`default_nettype none
module cirq_checker #(
	parameter int N_TX = 3
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Inputs watched
	input wire logic rx_to_fg_i,
	input wire logic rx_fifo_overrun_i,
	input wire logic [N_TX-1:0] tx_scheduled_i,
	input wire logic [1:0] tx_state_i,
	input wire logic [1:0] rx_state_i,
	input wire logic [7:0] rx_flag_clr_i,
	input wire logic status_change_irq_en_i,
	input wire logic overrun_irq_en_i,
	input wire logic rx_full_irq_en_i,
	input wire logic [N_TX-1:0] tx_empty_irq_en_i,
	input wire logic global_irq_mask_i,
	// Outputs watched
	input wire logic sleep_ack_o,
	input wire logic sleep_request_o,
	input wire logic status_change_flag_o,
	input wire logic overrun_flag_o,
	input wire logic rx_full_flag_o,
	input wire logic [N_TX-1:0] tx_empty_flag_o,
	input wire logic [1:0] tx_state_field_o,
	input wire logic error_irq_o,
	input wire logic rx_irq_o,
	input wire logic tx_irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	AST_ERR_IRQ: assert property (error_irq_o == (!global_irq_mask_i &&
		(status_change_flag_o && status_change_irq_en_i || overrun_flag_o && overrun_irq_en_i)))
		else $error("error request mismatch");
	AST_RX_IRQ: assert property (rx_irq_o == (!global_irq_mask_i && rx_full_flag_o && rx_full_irq_en_i))
		else $error("receive request mismatch");
	AST_TX_IRQ: assert property (tx_irq_o == (!global_irq_mask_i && |(tx_empty_flag_o & tx_empty_irq_en_i)))
		else $error("transmit request mismatch");
	AST_RX_SET: assert property (rx_to_fg_i && !sleep_ack_o |=> rx_full_flag_o)
		else $error("receive full not set");
	AST_OVR_SET: assert property (rx_fifo_overrun_i |=> overrun_flag_o)
		else $error("overrun not set");
	AST_TX_KEEP: assert property (!tx_scheduled_i[0] |=> tx_empty_flag_o[0])
		else $error("empty flag lost while unscheduled");
	AST_SC_HOLD: assert property (status_change_flag_o && !rx_flag_clr_i[6] |=> status_change_flag_o)
		else $error("status flag lost without clear");
	AST_SC_SET: assert property ($changed(tx_state_i) || $changed(rx_state_i) |=>
		status_change_flag_o && tx_state_field_o == $past(tx_state_i))
		else $error("status change not flagged");
	AST_SLEEP: assert property (sleep_ack_o |-> sleep_request_o)
		else $error("sleep ack without request");
	cover property (rx_irq_o);
	cover property (error_irq_o);
	cover property (sleep_ack_o);
endmodule
`default_nettype wire

/* File: cirq_ctrl.sv */
// Purpose: Interrupts, flag handshake, mode sequencing and bus-off recovery of a CAN core
// Assumes: All inputs synchronous to sys_clk_i; bit_tick_i marks one CAN bit time
// Notes: Flag clear ports carry write-one masks; a zero bit leaves the flag
`include "cirq_regs.svh"
`default_nettype none
module cirq_ctrl
	import cirq_pkg::*;
#(
	parameter int N_TX = `CIRQ_N_TX,
	parameter int RUN_BITS = `CIRQ_RUN_BITS,
	parameter int RUN_COUNT = `CIRQ_RUN_COUNT,
	parameter int INIT_SYNC_CYC = `CIRQ_INIT_SYNC_CYC
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Mode control
	input wire logic module_enable_i,
	input wire logic init_request_i,
	input wire logic sleep_request_i,
	input wire logic wake_enable_i,
	input wire logic power_down_i,
	output logic init_ack_o,
	output logic sleep_ack_o,
	output logic sleep_request_o,
	// Core status
	input wire logic bus_idle_i,
	input wire logic bus_activity_i,
	input wire logic bit_tick_i,
	input wire logic bus_recessive_i,
	input wire logic [1:0] tx_state_i,
	input wire logic [1:0] rx_state_i,
	input wire logic rx_to_fg_i,
	input wire logic rx_fifo_overrun_i,
	input wire logic [N_TX-1:0] tx_scheduled_i,
	input wire logic bus_off_i,
	// Bus-off recovery
	input wire logic busoff_recovery_mode_i,
	input wire logic busoff_hold_set_i,
	input wire logic busoff_hold_clr_i,
	output logic busoff_hold_o,
	output logic busoff_recover_o,
	// Interrupt enables
	input wire logic wake_irq_en_i,
	input wire logic status_change_irq_en_i,
	input wire logic overrun_irq_en_i,
	input wire logic rx_full_irq_en_i,
	input wire logic [N_TX-1:0] tx_empty_irq_en_i,
	input wire logic global_irq_mask_i,
	// Flag clear masks
	input wire logic [7:0] rx_flag_clr_i,
	input wire logic [N_TX-1:0] tx_flag_clr_i,
	// Flags and state fields
	output logic wake_flag_o,
	output logic status_change_flag_o,
	output logic overrun_flag_o,
	output logic rx_full_flag_o,
	output logic [N_TX-1:0] tx_empty_flag_o,
	output logic [1:0] tx_state_field_o,
	output logic [1:0] rx_state_field_o,
	// Interrupt requests
	output logic wake_irq_o,
	output logic error_irq_o,
	output logic rx_irq_o,
	output logic tx_irq_o
);
	cirq_mode_t mode_d, mode_q;
	logic [3:0] sync_d, sync_q;
	logic slept_d, slept_q;
	logic [1:0] tst_d, tst_q, rst_d, rst_q;
	cirq_bo_t bo_d, bo_q;
	logic [7:0] runs_d, runs_q;
	logic [3:0] bits_d, bits_q;
	logic hold_d, hold_q;
	logic recover_d, recover_q;
	logic fg_block;
	logic wake_ev;
	logic csc_ev;

	// Mode sequencing
	always_comb begin
		mode_d = mode_q;
		sync_d = sync_q;
		slept_d = slept_q;
		unique case (mode_q)
			CIRQ_DISABLED: begin
				if (module_enable_i) begin
					mode_d = CIRQ_INIT_SYNC;
					sync_d = 4'h0;
				end
			end
			CIRQ_INIT_SYNC: begin
				sync_d = sync_q + 4'h1;
				if (!init_request_i) begin
					mode_d = CIRQ_NORMAL;
				end else if (sync_q == 4'(INIT_SYNC_CYC - 1)) begin
					mode_d = CIRQ_INIT;
				end
			end
			CIRQ_INIT: begin
				if (!init_request_i) begin
					mode_d = CIRQ_NORMAL;
				end
			end
			CIRQ_NORMAL: begin
				if (init_request_i) begin
					mode_d = CIRQ_INIT_SYNC;
					sync_d = 4'h0;
				end else if (sleep_request_i) begin
					mode_d = CIRQ_SLEEP_WAIT;
				end
			end
			CIRQ_SLEEP_WAIT: begin
				if (!sleep_request_i) begin
					mode_d = CIRQ_NORMAL;
				end else if (bus_idle_i && (tx_scheduled_i == '0)) begin
					mode_d = CIRQ_SLEEP;
				end
			end
			CIRQ_SLEEP: begin
				if (init_request_i) begin
					mode_d = CIRQ_INIT_SYNC;
					sync_d = 4'h0;
				end else if (!sleep_request_i || (wake_enable_i && bus_activity_i)) begin
					mode_d = CIRQ_NORMAL;
				end
			end
			default: mode_d = CIRQ_DISABLED;
		endcase
		if (!module_enable_i) begin
			mode_d = CIRQ_DISABLED;
		end
		// Remember the sleep handshake for power-down wake-up
		if (mode_q == CIRQ_SLEEP) begin
			slept_d = 1'b1;
		end else if (!power_down_i) begin
			slept_d = 1'b0;
		end
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_q <= CIRQ_DISABLED;
			sync_q <= 4'h0;
			slept_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			sync_q <= sync_d;
			slept_q <= slept_d;
		end
	end
	assign init_ack_o = (mode_q == CIRQ_INIT);
	assign sleep_ack_o = (mode_q == CIRQ_SLEEP);
	assign sleep_request_o = sleep_request_i || (mode_q == CIRQ_SLEEP);

	// Event detection
	assign fg_block = (mode_q == CIRQ_SLEEP);
	assign wake_ev = wake_enable_i && bus_activity_i
		&& ((mode_q == CIRQ_SLEEP) || (power_down_i && slept_q));
	assign csc_ev = (tx_state_i != tst_q) || (rx_state_i != rst_q);
	always_comb begin
		tst_d = tx_state_i;
		rst_d = rx_state_i;
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tst_q <= `CIRQ_ST_ACTIVE;
			rst_q <= `CIRQ_ST_ACTIVE;
		end else begin
			tst_q <= tst_d;
			rst_q <= rst_d;
		end
	end
	assign tx_state_field_o = tst_q;
	assign rx_state_field_o = rst_q;

	// Receive-side flags
	cirq_flag u_wake (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.set_i(wake_ev),
		.cond_i(1'b0),
		.clr_i(rx_flag_clr_i[`CIRQ_RX_WAKE]),
		.flag_o(wake_flag_o)
	);
	cirq_flag u_csc (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.set_i(csc_ev),
		.cond_i(1'b0),
		.clr_i(rx_flag_clr_i[`CIRQ_RX_CSC]),
		.flag_o(status_change_flag_o)
	);
	cirq_flag u_ovr (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.set_i(rx_fifo_overrun_i),
		.cond_i(1'b0),
		.clr_i(rx_flag_clr_i[`CIRQ_RX_OVR]),
		.flag_o(overrun_flag_o)
	);
	cirq_flag u_rxf (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.set_i(rx_to_fg_i && !fg_block),
		.cond_i(1'b0),
		.clr_i(rx_flag_clr_i[`CIRQ_RX_FULL]),
		.flag_o(rx_full_flag_o)
	);

	// Transmit-side flags
	genvar gi;
	generate
		for (gi = 0; gi < N_TX; gi++) begin : g_tx
			cirq_flag u_txe (
				.sys_clk_i(sys_clk_i),
				.rst_i(rst_i),
				.set_i(1'b0),
				.cond_i(!tx_scheduled_i[gi]),
				.clr_i(tx_flag_clr_i[gi]),
				.flag_o(tx_empty_flag_o[gi])
			);
		end
	endgenerate

	// Interrupt requests
	assign wake_irq_o = !global_irq_mask_i && wake_flag_o && wake_irq_en_i;
	assign error_irq_o = !global_irq_mask_i
		&& ((status_change_flag_o && status_change_irq_en_i)
		|| (overrun_flag_o && overrun_irq_en_i));
	assign rx_irq_o = !global_irq_mask_i && rx_full_flag_o && rx_full_irq_en_i;
	assign tx_irq_o = !global_irq_mask_i
		&& ((tx_empty_flag_o & tx_empty_irq_en_i) != '0);

	// Bus-off recovery
	always_comb begin
		bo_d = bo_q;
		runs_d = runs_q;
		bits_d = bits_q;
		hold_d = hold_q;
		recover_d = 1'b0;
		if (busoff_hold_set_i && bus_off_i) begin
			hold_d = 1'b1;
		end else if (busoff_hold_clr_i) begin
			hold_d = 1'b0;
		end
		unique case (bo_q)
			CIRQ_BO_NONE: begin
				runs_d = 8'h00;
				bits_d = 4'h0;
				if (bus_off_i) begin
					bo_d = CIRQ_BO_COUNT;
					hold_d = busoff_recovery_mode_i;
				end
			end
			CIRQ_BO_COUNT: begin
				if (bit_tick_i && !fg_block) begin
					if (!bus_recessive_i) begin
						bits_d = 4'h0;
					end else if (bits_q == 4'(RUN_BITS - 1)) begin
						bits_d = 4'h0;
						runs_d = runs_q + 8'h01;
					end else begin
						bits_d = bits_q + 4'h1;
					end
				end
				if (runs_q == 8'(RUN_COUNT - 1) && bits_d == 4'h0 && runs_d != runs_q) begin
					bo_d = CIRQ_BO_WAIT_HOLD;
				end
			end
			CIRQ_BO_WAIT_HOLD: begin
				if (!busoff_recovery_mode_i || !hold_d) begin
					recover_d = 1'b1;
					bo_d = CIRQ_BO_NONE;
				end
			end
			default: bo_d = CIRQ_BO_NONE;
		endcase
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bo_q <= CIRQ_BO_NONE;
			runs_q <= 8'h00;
			bits_q <= 4'h0;
			hold_q <= 1'b0;
			recover_q <= 1'b0;
		end else begin
			bo_q <= bo_d;
			runs_q <= runs_d;
			bits_q <= bits_d;
			hold_q <= hold_d;
			recover_q <= recover_d;
		end
	end
	assign busoff_hold_o = hold_q;
	assign busoff_recover_o = recover_q;
endmodule
`default_nettype wire

/* File: cirq_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the CAN interrupt control block
// Assumes: Inputs change on the falling clock edge
// Notes: Receive full, overrun, status change and empty flags are predicted by a small reference model
`include "cirq_regs.svh"
`default_nettype none
module cirq_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int BIT_CYC = 2;
	localparam int RUN_CYC = `CIRQ_RUN_COUNT * `CIRQ_RUN_BITS * BIT_CYC;
	logic sys_clk_i = 0, rst_i = 1, module_enable_i = 0, init_request_i = 0, dominant = 0;
	logic sleep_request_i = 0, wake_enable_i = 0, power_down_i = 0, rx_to_fg_i = 0;
	logic bus_idle_i, bus_activity_i, bit_tick_i, bus_recessive_i, rx_fifo_overrun_i = 0;
	logic bus_off_i = 0, busoff_recovery_mode_i = 0, busoff_hold_set_i = 0;
	logic busoff_hold_clr_i = 0, wake_irq_en_i = 0, status_change_irq_en_i = 0;
	logic overrun_irq_en_i = 0, rx_full_irq_en_i = 0, global_irq_mask_i = 0;
	logic [1:0] tx_state_i = 0, rx_state_i = 0, tx_state_field_o, rx_state_field_o, ts, rs;
	logic [2:0] tx_scheduled_i = 0, tx_empty_irq_en_i = 0, tx_flag_clr_i = 0;
	logic [2:0] tx_empty_flag_o, tx_e;
	logic [7:0] rx_flag_clr_i = 0;
	logic init_ack_o, sleep_ack_o, sleep_request_o, busoff_hold_o, busoff_recover_o;
	logic wake_flag_o, status_change_flag_o, overrun_flag_o, rx_full_flag_o;
	logic wake_irq_o, error_irq_o, rx_irq_o, tx_irq_o, rx_e, ov_e, sc_e;
	int miscompares = 0, compares = 0, n;
	cirq_ctrl dut (.*);
	cirq_bus_model #(.BIT_CYC(BIT_CYC)) u_bus (.sys_clk_i, .rst_i, .dominant_i(dominant),
		.bit_tick_o(bit_tick_i), .recessive_o(bus_recessive_i), .activity_o(bus_activity_i),
		.idle_o(bus_idle_i));
	always #5ns sys_clk_i = ~sys_clk_i;
	function automatic logic gated(input logic a);
		return a & !global_irq_mask_i;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge sys_clk_i);
	endtask
	task automatic wait_for(ref logic s, input int lim);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(negedge sys_clk_i);
			n++;
		end
	endtask
	task automatic step();
		ts = tx_state_i;
		rs = rx_state_i;
		{rx_to_fg_i, rx_fifo_overrun_i} = 2'($urandom) & 2'($urandom);
		rx_flag_clr_i = 8'($urandom) & 8'h43;
		tx_flag_clr_i = 3'($urandom);
		tx_scheduled_i = 3'($urandom);
		{status_change_irq_en_i, overrun_irq_en_i, rx_full_irq_en_i} = 3'($urandom);
		tx_empty_irq_en_i = 3'($urandom);
		global_irq_mask_i = $urandom % 4 == 0;
		if ($urandom % 4 == 0) tx_state_i = 2'($urandom);
		if ($urandom % 4 == 0) rx_state_i = 2'($urandom);
		cyc(1);
		rx_e = rx_to_fg_i | rx_e & !rx_flag_clr_i[0];
		ov_e = rx_fifo_overrun_i | ov_e & !rx_flag_clr_i[1];
		sc_e = (tx_state_i != ts || rx_state_i != rs) | sc_e & !rx_flag_clr_i[6];
		tx_e = ~tx_scheduled_i | tx_e & ~tx_flag_clr_i;
		check(rx_full_flag_o, rx_e);
		check(overrun_flag_o, ov_e);
		check(status_change_flag_o, sc_e);
		check(tx_state_field_o, tx_state_i);
		check(rx_state_field_o, rx_state_i);
		check(tx_empty_flag_o, tx_e);
		check(error_irq_o, gated(sc_e & status_change_irq_en_i | ov_e & overrun_irq_en_i));
		check(rx_irq_o, gated(rx_e & rx_full_irq_en_i));
		check(tx_irq_o, gated(|(tx_e & tx_empty_irq_en_i)));
	endtask
	task automatic final_report();
		if (miscompares == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#200us;
		miscompares++;
		final_report();
	end
	initial begin
		void'($urandom(32'he796_1288));
		cyc(6);
		rst_i = 0;
		cyc(1);
		module_enable_i = 1;
		init_request_i = 1;
		cyc(4);
		check(init_ack_o, 0);
		wait_for(init_ack_o, 100);
		check(4 + n, 1 + `CIRQ_INIT_SYNC_CYC);
		init_request_i = 0;
		cyc(3);
		check(init_ack_o, 0);
		{rx_e, ov_e, sc_e, tx_e} = 6'h07;
		repeat (300) step();
		{rx_to_fg_i, rx_fifo_overrun_i, rx_flag_clr_i, tx_flag_clr_i, tx_scheduled_i} = '0;
		{wake_enable_i, wake_irq_en_i, global_irq_mask_i, sleep_request_i} = 4'hd;
		wait_for(sleep_ack_o, 100);
		check(sleep_request_o, 1);
		dominant = 1;
		cyc(3);
		dominant = 0;
		cyc(2);
		check(wake_flag_o, 1);
		check(wake_irq_o, 1);
		rx_flag_clr_i = 8'h80;
		cyc(1);
		rx_flag_clr_i = 8'h00;
		cyc(1);
		check(wake_flag_o, 0);
		wait_for(sleep_ack_o, 100);
		check(sleep_ack_o, 1);
		init_request_i = 1;
		wait_for(init_ack_o, 100);
		check(init_ack_o, 1);
		{init_request_i, sleep_request_i} = 2'h0;
		// Power-down without a prior sleep handshake must not wake
		power_down_i = 1;
		dominant = 1;
		cyc(2);
		{dominant, power_down_i} = 2'h0;
		check(wake_flag_o, 0);
		cyc(18);
		bus_off_i = 1;
		wait_for(busoff_recover_o, 4000);
		check(n >= RUN_CYC - 6 && n <= RUN_CYC + 6, 1);
		bus_off_i = 0;
		busoff_recovery_mode_i = 1;
		cyc(2);
		bus_off_i = 1;
		wait_for(busoff_recover_o, RUN_CYC + 40);
		check(n, RUN_CYC + 40);
		check(busoff_hold_o, 1);
		busoff_hold_clr_i = 1;
		cyc(1);
		busoff_hold_clr_i = 0;
		wait_for(busoff_recover_o, 20);
		check(n < 20, 1);
		busoff_recovery_mode_i = 0;
		cyc(2);
		check(busoff_hold_o, 0);
		busoff_hold_set_i = 1;
		cyc(1);
		busoff_hold_set_i = 0;
		check(busoff_hold_o, 1);
		final_report();
	end
endmodule
bind cirq_ctrl cirq_checker #(.N_TX(N_TX)) u_chk (.*);
`default_nettype wire

/* File: cirq_flag.sv */
// Purpose: One sticky interrupt flag with write-one clear
// Assumes: Set and clear strobes synchronous to the clock
// Notes: Set wins over clear; clear refused while condition holds
`default_nettype none
module cirq_flag (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_i,
	// Events
	input wire logic set_i,
	input wire logic cond_i,
	input wire logic clr_i,
	// State
	output logic flag_o
);
	logic flag_d;
	logic flag_q;
	always_comb begin
		flag_d = flag_q;
		if (clr_i && !cond_i) begin
			flag_d = 1'b0;
		end
		if (set_i || cond_i) begin
			flag_d = 1'b1;
		end
	end
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end
	assign flag_o = flag_q;
endmodule
`default_nettype wire

/* File: cirq_pkg.sv */
// Purpose: Types for the CAN interrupt, init and bus-off control block
// Assumes: Included constants header
// Notes: Mode machine states
`default_nettype none
package cirq_pkg;
	typedef enum logic [2:0] {
		CIRQ_DISABLED = 3'b000,
		CIRQ_INIT_SYNC = 3'b001,
		CIRQ_INIT = 3'b010,
		CIRQ_NORMAL = 3'b011,
		CIRQ_SLEEP_WAIT = 3'b100,
		CIRQ_SLEEP = 3'b101
	} cirq_mode_t;
	typedef enum logic [1:0] {
		CIRQ_BO_NONE = 2'b00,
		CIRQ_BO_COUNT = 2'b01,
		CIRQ_BO_WAIT_HOLD = 2'b10
	} cirq_bo_t;
endpackage
`default_nettype wire

/* File: cirq_regs.svh */
// Purpose: Constants for the CAN interrupt, init and bus-off control block
// Assumes: One clock domain, synchronous inputs
// Notes: Run figures are in CAN bit times counted by the recessive detector; CIRQ_INIT_SYNC_CYC is in clock cycles
`ifndef CIRQ_REGS_SVH
`define CIRQ_REGS_SVH
`define CIRQ_RUN_BITS 11
`define CIRQ_RUN_COUNT 128
`define CIRQ_INIT_SYNC_CYC 5
`define CIRQ_N_TX 3
`define CIRQ_RX_WAKE 7
`define CIRQ_RX_CSC 6
`define CIRQ_RX_OVR 1
`define CIRQ_RX_FULL 0
`define CIRQ_ST_ACTIVE 2'h0
`define CIRQ_ST_WARN 2'h1
`define CIRQ_ST_PASSIVE 2'h2
`define CIRQ_ST_BUSOFF 2'h3
`endif
